// File: rtl/cpm_pkg.sv
// Shared constants and types of the clock and power-mode controller
package cpm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned IRC_MHZ = 4;
  localparam int unsigned NIRQ = 8;
  localparam int unsigned NPER = 4;
  // Times as printed, then derived counts (least times round up)
  localparam int unsigned OSC_START_NS = 60000;
  localparam int unsigned OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FLASH_WAKE_NS = 100000;
  localparam int unsigned FLASH_WAKE_IRC = (FLASH_WAKE_NS * IRC_MHZ + 999) / 1000;
  localparam logic [12:0] DS_IRC_CYC = 13'h0004;
  localparam logic [12:0] DS_XTAL_CYC = 13'h1000;
  localparam logic [12:0] PD_IRC_CYC = 13'h0004;
  localparam int unsigned XTAL_STABLE_DEF = 1024;
  localparam logic [3:0] LOCK_REFS = 4'h8;
  // Register indices
  localparam logic [3:0] REG_SRC = 4'h0;
  localparam logic [3:0] REG_MCTRL = 4'h1;
  localparam logic [3:0] REG_MCFG = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_DIV = 4'h4;
  localparam logic [3:0] REG_PSEL = 4'h5;
  localparam logic [3:0] REG_UCTRL = 4'h6;
  localparam logic [3:0] REG_PWR = 4'h7;
  // Field positions
  localparam int unsigned F_EN = 0;
  localparam int unsigned F_CONN = 1;
  localparam int unsigned F_MM1 = 8;
  localparam int unsigned F_UDIV = 8;
  // Source select and power requests
  localparam logic [1:0] SRC_IRC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;
  localparam logic [1:0] PWR_SLEEP = 2'h1;
  localparam logic [1:0] PWR_DSLEEP = 2'h2;
  localparam logic [1:0] PWR_PDOWN = 2'h3;
  // Reset values
  localparam logic [7:0] RST_N_M1 = 8'h00;
  localparam logic [14:0] RST_M_M1 = 15'h0000;
  localparam logic [7:0] RST_CPU_DIV = 8'h00;
  localparam logic [3:0] RST_USB_DIV = 4'h0;
  localparam logic [2*NPER-1:0] RST_PSEL = 8'h00;

  typedef enum logic [2:0] {M_RUN, M_SLEEP, M_DSLEEP, M_PDOWN, M_OSCUP, M_WAKE, M_DPD} cpm_mode_t;

  typedef struct packed {
    logic rtc;
    logic xtal;
    logic internal_rc_osc;
  } cpm_ticks_t;

  typedef struct packed {
    logic core_pwr;
    logic flash_pwr;
    logic irc_out;
    logic irc_pwr;
  } cpm_pwr_t;
endpackage

// File: rtl/cpm_top.sv
// Clock source selection, multiplying loops, dividers and power-mode sequencing
// Functional notes
// R1 - Reset selects internal RC oscillator
// R2 - Software selects any of three sources
// R3 - Pre-divide N from 1 to 256
// R4 - Multiply M up to 32768, phase compare
// R5 - Software keeps oscillator within 275-550 MHz
// R6 - Main loop off after reset, power-down
// R7 - Software enables, waits lock, then connects
// R8 - CPU clock equals input unless connected
// R9 - Each peripheral has own divider
// R10 - USB loop crystal-fed, off at reset
// R11 - USB input 10-25 MHz, 50% duty
// R12 - Sleep stops core; interrupt restores it
// R13 - Deep-sleep stops all internal clocks
// R14 - Deep-sleep entry clears loop and dividers
// R15 - Deep-sleep wake after 4 or 4096 cycles
// R16 - Power-down also cuts oscillator, flash power
// R17 - Power-down wake: 60 us then 4 cycles
// R18 - Flash blocked until 100 us timer
// R19 - Deep power-down only on clock-block request; code enters it on RTC_DPD_REQ_I
// R20 - Deep power-down exit: reset or alarm
// R21 - Wake mask latched on entry, wakes CPU
// R22 - Crystal held off until judged stable
// R23 - Source switching without clock glitches
// R24 - Main loop lock flag readable
`timescale 1ns/10ps
`default_nettype none
module cpm_top
  import cpm_pkg::*;
#(
  parameter int unsigned OSC_START = OSC_START_CYC,
  parameter int unsigned XTAL_STABLE = XTAL_STABLE_DEF
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire cpm_ticks_t OSC_TICK_I,
  input wire logic MAIN_CCO_TICK_I,
  input wire logic USB_CCO_TICK_I,
  input wire logic USB_LOCK_I,
  input wire logic [NIRQ-1:0] IRQ_I,
  input wire logic [NIRQ-1:0] IRQ_MASK_I,
  input wire logic RTC_DPD_REQ_I,
  input wire logic RTC_ALARM_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic CPU_CLK_EN_O,
  output logic [NPER-1:0] PCLK_EN_O,
  output logic USB_CLK_O,
  output logic MAIN_LOOP_EN_O,
  output logic USB_LOOP_EN_O,
  output logic FLASH_READY_O,
  output cpm_pwr_t PWR_O
);
  function automatic logic [15:0] div_next(input logic tick, input logic [15:0] cnt, input logic [15:0] lim);
    div_next = !tick ? cnt : (cnt >= lim) ? 16'h0000 : cnt + 16'h0001;
  endfunction

  cpm_mode_t mode;
  logic [1:0] src;
  logic main_en, main_conn, usb_en;
  logic [7:0] n_m1;
  logic [14:0] m_m1;
  logic [7:0] cpu_div;
  logic [3:0] usb_div;
  logic [2*NPER-1:0] psel;
  logic [NIRQ-1:0] wic_mask;
  logic [1:0] entry_src;
  logic [12:0] wcnt, wake_lim;
  logic wake_xtal;
  logic [15:0] ref_cnt, fb_cnt, cpu_cnt, usb_cnt;
  logic [15:0] per_cnt [NPER];
  logic [1:0] fb_seen;
  logic [3:0] lock_cnt;
  logic main_lock;
  logic [12:0] xtal_cnt;
  logic xtal_ok;
  logic [8:0] flash_cnt;
  logic flash_run;

  wire wr_src = WR_I && ADDR_I == REG_SRC;
  wire wr_pwr = WR_I && ADDR_I == REG_PWR;
  wire [1:0] pwr_req = WDATA_I[1:0];
  wire run = mode == M_RUN;
  wire clocks_on = run || mode == M_SLEEP; // [R13]
  wire go_sleep = run && wr_pwr && pwr_req == PWR_SLEEP;
  wire go_ds = run && wr_pwr && pwr_req == PWR_DSLEEP;
  wire go_pd = run && wr_pwr && pwr_req == PWR_PDOWN;
  wire go_dpd = run && RTC_DPD_REQ_I && !wr_pwr; // [R19]
  wire go_deep = go_ds || go_pd || go_dpd;
  wire wic_wake = |(IRQ_I & wic_mask); // [R21]
  wire dpd_exit = mode == M_DPD && RTC_ALARM_I; // [R20]
  // Crystal stays unusable until its start-up count has run out
  wire [1:0] eff_src = (src == SRC_XTAL && !xtal_ok) ? SRC_IRC : src; // [R22]
  wire src_tick = eff_src == SRC_XTAL ? OSC_TICK_I.xtal :
                  eff_src == SRC_RTC ? OSC_TICK_I.rtc : OSC_TICK_I.internal_rc_osc; // [R2]
  wire main_act = main_en && main_conn; // [R8]
  // Sources are single-cycle enables, so a switch never yields a short pulse
  wire base_tick = clocks_on && (main_act ? MAIN_CCO_TICK_I : src_tick); // [R23]
  wire cpu_tick = base_tick && cpu_cnt >= {8'h00, cpu_div};
  wire ref_tick = main_en && src_tick && ref_cnt >= {8'h00, n_m1}; // [R3]
  wire fb_tick = main_en && MAIN_CCO_TICK_I && fb_cnt >= {1'b0, m_m1}; // [R4]
  wire [1:0] fb_hits = fb_seen + {1'b0, fb_tick};
  wire usb_own = usb_en && USB_LOCK_I;
  wire usb_main_tick = clocks_on && main_en && MAIN_CCO_TICK_I && usb_cnt >= {12'h000, usb_div};
  wire usb_tick = clocks_on && (usb_own ? USB_CCO_TICK_I : usb_main_tick); // [R10]
  wire wake_tick = wake_xtal ? OSC_TICK_I.xtal : OSC_TICK_I.internal_rc_osc;

  // Power-mode sequencer
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode <= M_RUN;
      wic_mask <= '0;
      entry_src <= SRC_IRC;
      wcnt <= '0;
      wake_lim <= DS_IRC_CYC;
      wake_xtal <= 1'b0;
    end else begin
      case (mode)
        M_RUN: begin
          wcnt <= '0;
          entry_src <= eff_src;
          if (go_deep) begin
            wic_mask <= IRQ_MASK_I; // [R21]
          end
          if (go_sleep) begin
            mode <= M_SLEEP; // [R12]
          end else if (go_ds) begin
            mode <= M_DSLEEP;
          end else if (go_pd) begin
            mode <= M_PDOWN;
          end else if (go_dpd) begin
            mode <= M_DPD;
          end
        end
        M_SLEEP: begin
          if (|IRQ_I) begin
            mode <= M_RUN; // [R12]
          end
        end
        M_DSLEEP: begin
          if (wic_wake) begin
            mode <= M_WAKE;
            wake_xtal <= entry_src == SRC_XTAL;
            wake_lim <= entry_src == SRC_XTAL ? DS_XTAL_CYC : DS_IRC_CYC; // [R15]
          end
        end
        M_PDOWN: begin
          if (wic_wake) begin
            mode <= M_OSCUP;
          end
        end
        M_DPD: begin
          if (RTC_ALARM_I) begin
            mode <= M_OSCUP; // [R20]
          end
        end
        M_OSCUP: begin
          // Oscillator start-up time counted in system clocks
          if (wcnt >= 13'(OSC_START - 1)) begin
            mode <= M_WAKE;
            wcnt <= '0;
            wake_xtal <= 1'b0;
            wake_lim <= PD_IRC_CYC; // [R17]
          end else begin
            wcnt <= wcnt + 13'h0001;
          end
        end
        M_WAKE: begin
          if (wake_tick) begin
            wcnt <= wcnt + 13'h0001;
            if (wcnt + 13'h0001 >= wake_lim) begin
              mode <= M_RUN; // [R15]
            end
          end
        end
        default: mode <= M_RUN;
      endcase
    end
  end

  // Software configuration; deep modes clear the main loop enable and connect bits and the CPU and USB dividers on entry
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      src <= SRC_IRC; // [R1]
      main_en <= 1'b0; // [R6]
      main_conn <= 1'b0;
      usb_en <= 1'b0; // [R10]
      n_m1 <= RST_N_M1;
      m_m1 <= RST_M_M1;
      cpu_div <= RST_CPU_DIV;
      usb_div <= RST_USB_DIV;
      psel <= RST_PSEL;
    end else if (dpd_exit) begin
      src <= SRC_IRC; // [R1]
      main_en <= 1'b0;
      main_conn <= 1'b0;
      usb_en <= 1'b0;
      n_m1 <= RST_N_M1;
      m_m1 <= RST_M_M1;
      cpu_div <= RST_CPU_DIV;
      usb_div <= RST_USB_DIV;
      psel <= RST_PSEL;
    end else if (go_deep) begin
      main_en <= 1'b0; // [R14] [R6] [R16]
      main_conn <= 1'b0;
      cpu_div <= '0; // [R14]
      usb_div <= '0;
      if (go_pd) begin
        src <= SRC_IRC; // [R17]
      end
    end else if (WR_I) begin
      if (wr_src) begin
        src <= WDATA_I[1:0] == 2'h3 ? SRC_IRC : WDATA_I[1:0]; // [R2]
      end else if (ADDR_I == REG_MCTRL) begin
        main_en <= WDATA_I[F_EN]; // [R7]
        main_conn <= WDATA_I[F_CONN];
      end else if (ADDR_I == REG_MCFG) begin
        n_m1 <= WDATA_I[7:0]; // [R3]
        m_m1 <= WDATA_I[F_MM1 +: 15]; // [R4]
      end else if (ADDR_I == REG_DIV) begin
        cpu_div <= WDATA_I[7:0];
        usb_div <= WDATA_I[F_UDIV +: 4];
      end else if (ADDR_I == REG_PSEL) begin
        psel <= WDATA_I[2*NPER-1:0]; // [R9]
      end else if (ADDR_I == REG_UCTRL) begin
        usb_en <= WDATA_I[F_EN]; // [R10]
      end
    end
  end

  // Main loop dividers and lock detection
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_cnt <= '0;
      fb_cnt <= '0;
      fb_seen <= '0;
      lock_cnt <= '0;
      main_lock <= 1'b0;
    end else if (!main_en) begin
      ref_cnt <= '0;
      fb_cnt <= '0;
      fb_seen <= '0;
      lock_cnt <= '0;
      main_lock <= 1'b0;
    end else begin
      ref_cnt <= div_next(src_tick, ref_cnt, {8'h00, n_m1}); // [R3]
      fb_cnt <= div_next(MAIN_CCO_TICK_I, fb_cnt, {1'b0, m_m1}); // [R4]
      if (ref_tick) begin
        fb_seen <= '0;
        // Exactly one feedback edge per reference period counts as in phase
        if (fb_hits == 2'h1) begin
          if (lock_cnt >= LOCK_REFS - 4'h1) begin
            main_lock <= 1'b1; // [R24]
          end else begin
            lock_cnt <= lock_cnt + 4'h1;
          end
        end else begin
          lock_cnt <= '0;
          main_lock <= 1'b0;
        end
      end else if (fb_tick && fb_seen != 2'h3) begin
        fb_seen <= fb_hits;
      end
    end
  end

  // Clock dividers; CPU output is a registered enable, USB output a registered toggle
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cpu_cnt <= '0;
      usb_cnt <= '0;
      CPU_CLK_EN_O <= 1'b0;
      USB_CLK_O <= 1'b0;
    end else begin
      cpu_cnt <= div_next(base_tick, cpu_cnt, {8'h00, cpu_div});
      usb_cnt <= div_next(clocks_on && MAIN_CCO_TICK_I, usb_cnt, {12'h000, usb_div});
      CPU_CLK_EN_O <= run && cpu_tick; // [R12] [R8]
      if (usb_tick) begin
        USB_CLK_O <= !USB_CLK_O; // [R11]
      end
    end
  end

  for (genvar p = 0; p < NPER; p++) begin : g_per
    wire [15:0] plim = (16'h0001 << psel[2*p +: 2]) - 16'h0001;
    always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
        per_cnt[p] <= '0;
        PCLK_EN_O[p] <= 1'b0;
      end else begin
        per_cnt[p] <= div_next(cpu_tick, per_cnt[p], plim); // [R9]
        PCLK_EN_O[p] <= cpu_tick && per_cnt[p] >= plim;
      end
    end
  end

  // Crystal stability and flash wake-up timers
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      xtal_cnt <= '0;
      xtal_ok <= 1'b0;
      flash_cnt <= '0;
      flash_run <= 1'b0;
      FLASH_READY_O <= 1'b1;
    end else begin
      if (go_pd || go_dpd) begin
        xtal_cnt <= '0;
        xtal_ok <= 1'b0; // [R22]
        FLASH_READY_O <= 1'b0; // [R16]
        flash_run <= 1'b0;
      end else if (mode != M_PDOWN && mode != M_DPD && !xtal_ok && OSC_TICK_I.xtal) begin
        if (xtal_cnt >= 13'(XTAL_STABLE - 1)) begin
          xtal_ok <= 1'b1; // [R22]
        end else begin
          xtal_cnt <= xtal_cnt + 13'h0001;
        end
      end
      if (mode == M_OSCUP && wcnt >= 13'(OSC_START - 1)) begin
        flash_run <= 1'b1;
        flash_cnt <= '0;
      end else if (flash_run && OSC_TICK_I.internal_rc_osc) begin
        if (flash_cnt >= 9'(FLASH_WAKE_IRC - 1)) begin
          flash_run <= 1'b0;
          FLASH_READY_O <= 1'b1; // [R18]
        end else begin
          flash_cnt <= flash_cnt + 9'h001;
        end
      end
    end
  end

  // Power switches and loop enables
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PWR_O <= '{core_pwr: 1'b1, flash_pwr: 1'b1, irc_out: 1'b1, irc_pwr: 1'b1};
      MAIN_LOOP_EN_O <= 1'b0;
      USB_LOOP_EN_O <= 1'b0;
    end else begin
      PWR_O.irc_out <= clocks_on || mode == M_WAKE; // [R13]
      PWR_O.irc_pwr <= mode != M_PDOWN && mode != M_DPD; // [R16]
      PWR_O.flash_pwr <= mode != M_PDOWN && mode != M_DPD && !(mode == M_OSCUP && !flash_run && !FLASH_READY_O);
      PWR_O.core_pwr <= mode != M_DPD; // [R19]
      MAIN_LOOP_EN_O <= main_en && !go_deep; // [R6]
      USB_LOOP_EN_O <= usb_en && clocks_on; // [R10]
    end
  end

  // Register read port, data valid in the cycle after the strobe
  wire [31:0] stat = {21'h0, mode, 2'h0, FLASH_READY_O, xtal_ok, USB_LOCK_I && usb_en, main_act, main_en, main_lock};
  wire [31:0] rmux = ADDR_I == REG_SRC ? {30'h0, src} :
                     ADDR_I == REG_MCTRL ? {30'h0, main_conn, main_en} :
                     ADDR_I == REG_MCFG ? {9'h0, m_m1, n_m1} :
                     ADDR_I == REG_STAT ? stat : // [R24]
                     ADDR_I == REG_DIV ? {20'h0, usb_div, cpu_div} :
                     ADDR_I == REG_PSEL ? {24'h0, psel} :
                     ADDR_I == REG_UCTRL ? {31'h0, usb_en} : 32'h0000_0000;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= '0;
    end else begin
      RDATA_O <= RD_I ? rmux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// File: verif/cpm_top_props.sv
// Port assertions of the clock and power-mode controller
`timescale 1ns/10ps
`default_nettype none
module cpm_top_chk
  import cpm_pkg::*;
#(
  parameter int unsigned OSC_START = OSC_START_CYC,
  parameter int unsigned XTAL_STABLE = XTAL_STABLE_DEF
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire cpm_ticks_t OSC_TICK_I,
  input wire logic [NIRQ-1:0] IRQ_I,
  input wire logic RTC_DPD_REQ_I,
  input wire logic RTC_ALARM_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic CPU_CLK_EN_O,
  input wire logic [NPER-1:0] PCLK_EN_O,
  input wire logic MAIN_LOOP_EN_O,
  input wire logic FLASH_READY_O,
  input wire cpm_pwr_t PWR_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Counts from the moment flash is blocked, so it is only an upper bound on the wake timer
  logic [15:0] irc_seen;
  wire logic pwr_wr = WR_I && ADDR_I == REG_PWR && WDATA_I[1:0] != 2'h0;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I || FLASH_READY_O) begin
      irc_seen <= 16'h0000;
    end else if (OSC_TICK_I.internal_rc_osc && irc_seen != 16'hffff) begin
      irc_seen <= irc_seen + 16'h0001;
    end
  end
  property p_rd_idle; !$past(RD_I) |-> RDATA_O == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rd_unmap; RD_I && ADDR_I[3] |=> RDATA_O == 32'h0; endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_rst; $fell(RST_I) |-> FLASH_READY_O && PWR_O == 4'hf && !MAIN_LOOP_EN_O && !CPU_CLK_EN_O; endproperty
  a_rst: assert property (p_rst) else $error("bad values after reset");
  property p_sleep; pwr_wr ##1 IRQ_I == 8'h00 |=> !CPU_CLK_EN_O; endproperty
  a_sleep: assert property (p_sleep) else $error("core clock not stopped");
  property p_deep_loop; pwr_wr && WDATA_I[1] |-> ##2 !MAIN_LOOP_EN_O; endproperty
  a_deep_loop: assert property (p_deep_loop) else $error("main loop left on");
  property p_flash_off; !PWR_O.flash_pwr |-> !FLASH_READY_O; endproperty
  a_flash_off: assert property (p_flash_off) else $error("flash ready while unpowered");
  property p_irc_gate; !PWR_O.irc_out && !$past(PWR_O.irc_out) |-> !CPU_CLK_EN_O && PCLK_EN_O == '0; endproperty
  a_irc_gate: assert property (p_irc_gate) else $error("clock runs while gated");
  property p_dpd_in; $fell(PWR_O.core_pwr) |-> $past(RTC_DPD_REQ_I) || $past(RTC_DPD_REQ_I, 2); endproperty
  a_dpd_in: assert property (p_dpd_in) else $error("core off without request");
  property p_dpd_hold; !PWR_O.core_pwr && !RTC_ALARM_I && !$past(RTC_ALARM_I) |=> !PWR_O.core_pwr; endproperty
  a_dpd_hold: assert property (p_dpd_hold) else $error("core on without alarm");
  property p_flash_wait; $rose(FLASH_READY_O) |-> irc_seen >= FLASH_WAKE_IRC; endproperty
  a_flash_wait: assert property (p_flash_wait) else $error("flash ready too early");
  c_pwr: cover property (pwr_wr);
  c_dpd: cover property ($fell(PWR_O.core_pwr));
  c_flash: cover property ($rose(FLASH_READY_O));
endmodule
bind cpm_top cpm_top_chk #(.OSC_START(OSC_START), .XTAL_STABLE(XTAL_STABLE)) u_chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .OSC_TICK_I(OSC_TICK_I), .IRQ_I(IRQ_I), .RTC_DPD_REQ_I(RTC_DPD_REQ_I),
  .RTC_ALARM_I(RTC_ALARM_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .CPU_CLK_EN_O(CPU_CLK_EN_O), .PCLK_EN_O(PCLK_EN_O), .MAIN_LOOP_EN_O(MAIN_LOOP_EN_O),
  .FLASH_READY_O(FLASH_READY_O), .PWR_O(PWR_O)
);
`default_nettype wire

// File: verif/cpm_top_tb.sv
// Self-checking bench of the clock and power-mode controller
`timescale 1ns/10ps
`default_nettype none
module cpm_top_tb
  import cpm_pkg::*;
;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} cpm_row_t;
  logic MCLK_I, RST_I, MAIN_CCO_TICK_I, USB_CCO_TICK_I, USB_LOCK_I, WR_I, RD_I, RTC_DPD_REQ_I, RTC_ALARM_I;
  logic CPU_CLK_EN_O, USB_CLK_O, MAIN_LOOP_EN_O, USB_LOOP_EN_O, FLASH_READY_O;
  cpm_ticks_t OSC_TICK_I;
  cpm_pwr_t PWR_O;
  logic [NIRQ-1:0] IRQ_I, IRQ_MASK_I;
  logic [NPER-1:0] PCLK_EN_O;
  logic [3:0] ADDR_I;
  logic [31:0] WDATA_I, RDATA_O, rv;
  int n_errors = 0, checks = 0, cyc = 0, dt, n, np;
  cpm_row_t rows [9] = '{'{REG_SRC, 32'h1, 32'h1}, '{REG_SRC, 32'h2, 32'h2}, '{REG_SRC, 32'h3, 32'h0},
    '{REG_MCFG, 32'h7fffff, 32'h7fffff}, '{REG_MCFG, 32'h100, 32'h100}, '{REG_DIV, 32'hf07, 32'hf07},
    '{REG_PSEL, 32'he4, 32'he4}, '{4'h9, 32'hffffffff, 32'h0}, '{REG_UCTRL, 32'h1, 32'h1}};
  cpm_top #(.OSC_START(20), .XTAL_STABLE(8)) dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .OSC_TICK_I(OSC_TICK_I),
    .MAIN_CCO_TICK_I(MAIN_CCO_TICK_I), .USB_CCO_TICK_I(USB_CCO_TICK_I), .USB_LOCK_I(USB_LOCK_I), .IRQ_I(IRQ_I),
    .IRQ_MASK_I(IRQ_MASK_I), .RTC_DPD_REQ_I(RTC_DPD_REQ_I), .RTC_ALARM_I(RTC_ALARM_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CPU_CLK_EN_O(CPU_CLK_EN_O),
    .PCLK_EN_O(PCLK_EN_O), .USB_CLK_O(USB_CLK_O), .MAIN_LOOP_EN_O(MAIN_LOOP_EN_O),
    .USB_LOOP_EN_O(USB_LOOP_EN_O), .FLASH_READY_O(FLASH_READY_O), .PWR_O(PWR_O));
  initial begin
    MCLK_I = 1'b0;
    forever #5 MCLK_I = ~MCLK_I;
  end
  // INTERNAL_RC_OSC 4 MHz, crystal 12.5 MHz; loop oscillator ticks twice per INTERNAL_RC_OSC period so N=1, M=2 locks
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    OSC_TICK_I <= {cyc % 100 == 0, cyc % 8 == 0, cyc % 25 == 0};
    MAIN_CCO_TICK_I <= (cyc % 25 == 0) || (cyc % 25 == 12);
    USB_CCO_TICK_I <= (cyc % 3 == 0);
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge MCLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge MCLK_I);
    RD_I <= 1'b0;
    #1 d = RDATA_O;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int t;
    t = cyc;
    rd(REG_STAT, rv);
    for (int i = 0; i < 20000 && rv[10:8] !== m; i++) rd(REG_STAT, rv);
    dt = cyc - t;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge MCLK_I);
    n_errors++;
    summarize();
  end
  initial begin
    RST_I = 1'b1;
    {MAIN_CCO_TICK_I, USB_CCO_TICK_I, WR_I, RD_I, RTC_DPD_REQ_I, RTC_ALARM_I, IRQ_I, ADDR_I, WDATA_I} = '0;
    OSC_TICK_I = '0;
    USB_LOCK_I = 1'b1;
    IRQ_MASK_I = 8'h01;
    repeat (20) @(posedge MCLK_I);
    RST_I <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      check("reg", rv, rows[i].e);
    end
    check("usb en", 32'(USB_LOOP_EN_O), 32'h1);
    n = 0;
    repeat (60) begin
      @(posedge MCLK_I);
      if (USB_CLK_O === 1'b1) n++;
    end
    check("usb duty", n, 30);
    USB_LOCK_I <= 1'b0;
    rd(REG_STAT, rv);
    check("usb lock", rv[3], 1'b0);
    USB_LOCK_I <= 1'b1;
    wr(REG_MCTRL, 32'h1);
    rv = '0;
    for (int i = 0; i < 300 && rv[0] !== 1'b1; i++) rd(REG_STAT, rv);
    check("lock", rv[0], 1'b1);
    check("loop en", MAIN_LOOP_EN_O, 1'b1);
    wr(REG_MCTRL, 32'h3);
    rd(REG_STAT, rv);
    check("connected", rv[2:0], 3'h7);
    wr(REG_PWR, 32'h1);
    @(posedge MCLK_I);
    n = 0;
    np = 0;
    repeat (600) begin
      @(posedge MCLK_I);
      #1;
      if (CPU_CLK_EN_O !== 1'b0) n++;
      if (PCLK_EN_O != '0) np++;
    end
    check("cpu stop", n, 0);
    check("pclk run", 32'(np != 0), 32'h1);
    IRQ_I <= 8'h80;
    wait_mode(3'h0);
    IRQ_I <= 8'h00;
    check("sleep wake", 32'(dt < 8), 32'h1);
    // First pass wakes on INTERNAL_RC_OSC timing, second on crystal timing
    for (int s = 0; s < 2; s++) begin
      IRQ_MASK_I <= 8'h01;
      wr(REG_SRC, s);
      wr(REG_PWR, 32'h2);
      IRQ_MASK_I <= 8'h02;
      IRQ_I <= 8'h02;
      repeat (50) @(posedge MCLK_I);
      rd(REG_STAT, rv);
      check("dsleep", rv[10:8], 3'h2);
      check("dsleep loop", MAIN_LOOP_EN_O, 1'b0);
      check("dsleep pwr", PWR_O, 4'hd);
      IRQ_I <= 8'h01;
      wait_mode(3'h0);
      IRQ_I <= 8'h00;
      check("dsleep wake", 32'(s ? dt >= 32750 && dt <= 33000 : dt >= 70 && dt <= 140), 32'h1);
      rd(REG_MCTRL, rv);
      check("mctrl clr", rv, 32'h0);
      rd(REG_DIV, rv);
      check("div clr", rv, 32'h0);
    end
    wr(REG_PWR, 32'h3);
    repeat (2) @(posedge MCLK_I);
    #1;
    check("pd pwr", PWR_O, 4'h8);
    // Mask latched at entry is the one left from the deep-sleep pass
    np = cyc;
    IRQ_I <= 8'h02;
    wait_mode(3'h0);
    IRQ_I <= 8'h00;
    check("pd wake", 32'(dt >= 90 && dt <= 160), 32'h1);
    check("flash blocked", FLASH_READY_O, 1'b0);
    rd(REG_SRC, rv);
    check("pd src", rv, 32'h0);
    for (int i = 0; i < 12000 && FLASH_READY_O !== 1'b1; i++) @(posedge MCLK_I);
    check("flash wait", 32'(cyc - np >= 9900), 32'h1);
    check("flash ready", FLASH_READY_O, 1'b1);
    RTC_DPD_REQ_I <= 1'b1;
    @(posedge MCLK_I);
    RTC_DPD_REQ_I <= 1'b0;
    IRQ_I <= 8'hff;
    repeat (50) @(posedge MCLK_I);
    #1;
    check("dpd core", PWR_O.core_pwr, 1'b0);
    IRQ_I <= 8'h00;
    RTC_ALARM_I <= 1'b1;
    wait_mode(3'h0);
    RTC_ALARM_I <= 1'b0;
    check("dpd exit", PWR_O.core_pwr, 1'b1);
    wr(REG_MCTRL, 32'h1);
    wr(REG_SRC, 32'h2);
    RST_I <= 1'b1;
    repeat (3) @(posedge MCLK_I);
    #1;
    check("rst loop", MAIN_LOOP_EN_O, 1'b0);
    check("rst pwr", {PWR_O, FLASH_READY_O}, 5'h1f);
    RST_I <= 1'b0;
    rd(REG_STAT, rv);
    check("xtal hold", rv[4], 1'b0);
    rd(REG_SRC, rv);
    check("rst src", rv, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
